// ===== acc_ctrl.sv
`timescale 1ns/1ps
module acc_ctrl
  import acc_pkg::*;
#(
  parameter int NCH = ACC_NCH,
  parameter int STARTUP_CYC = ACC_STARTUP_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // sampling rate strobe
  input wire logic sample_tick_i,
  // configuration write
  input wire logic cfg_we_i,
  input wire logic wp_en_i,
  input wire logic dbg_access_i,
  input wire logic [1:0] comp_en_i,
  input wire logic [1:0] single_i,
  input wire logic [3:0] intsel_i,
  input wire logic [3:0] flen_i,
  input wire logic [3:0] mux_pos_i,
  input wire logic [5:0] mux_neg_i,
  input wire logic [11:0] scaler_i,
  input wire logic [1:0] out_sync_i,
  input wire logic [1:0] run_stby_i,
  input wire logic win_en_i,
  input wire logic [1:0] win_sel_i,
  input wire logic dbg_halt_i,
  // unprotected controls
  input wire logic [1:0] start_i,
  input wire logic [2:0] flag_clr_i,
  input wire logic [2:0] int_mask_i,
  // system state
  input wire logic sleep_i,
  input wire logic cpu_halted_i,
  // analog side
  input wire logic [1:0] comp_raw_i,
  output logic [1:0] comp_on_o,
  output logic [3:0] mux_pos_o,
  output logic [5:0] mux_neg_o,
  output logic [11:0] scaler_o,
  // pins
  output logic [1:0] cmp_pin_o,
  // status
  output logic [1:0] comp_state_o,
  output logic [1:0] comp_ready_o,
  output logic win_inside_o,
  output logic [2:0] flags_o,
  output logic sync_busy_o,
  output logic wp_err_o,
  // events and interrupts
  output logic [1:0] evt_comp_o,
  output logic evt_win_o,
  output logic irq_o,
  output logic wake_o
);
  logic [ACC_CFG_W-1:0] pend_ff;
  logic [ACC_CFG_W-1:0] act_ff;
  logic [1:0] raw_pin_ff;
  logic win_cond_ff;
  logic win_inside_ff;

  wire [ACC_CFG_W-1:0] cfg_w = {dbg_halt_i, win_sel_i, win_en_i, run_stby_i, out_sync_i, scaler_i,
                                mux_neg_i, mux_pos_i, flen_i, intsel_i, single_i, comp_en_i};
  // debugger writes bypass protection; start and flag clear have no write path here
  wire wr_ok = cfg_we_i && (!wp_en_i || dbg_access_i); // RULE_14 RULE_15
  wire wr_bad = cfg_we_i && wp_en_i && !dbg_access_i; // RULE_14
  // applying only on a sample strobe keeps settings steady within one sample period
  wire apply = sync_busy_o && sample_tick_i; // RULE_12

  wire [1:0] en_w = act_ff[ACC_CF_EN +: 2];
  wire [1:0] single_w = act_ff[ACC_CF_SINGLE +: 2];
  wire [3:0] intsel_w = act_ff[ACC_CF_INTSEL +: 4];
  wire [3:0] flen_w = act_ff[ACC_CF_FLEN +: 4];
  wire [1:0] outsync_w = act_ff[ACC_CF_OUTSYNC +: 2];
  wire [1:0] runstby_w = act_ff[ACC_CF_RUNSTBY +: 2];
  wire win_en_w = act_ff[ACC_CF_WINEN];
  wire [1:0] win_sel_w = act_ff[ACC_CF_WINSEL +: 2];
  wire dbg_halt_w = act_ff[ACC_CF_DBGHALT];

  wire [1:0] st_w;
  wire [1:0] rdy_w;
  wire [1:0] done_w;
  wire [1:0] int_w;
  wire [1:0] halt_w;

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      assign halt_w[c] = (cpu_halted_i && dbg_halt_w) || (sleep_i && !runstby_w[c]); // RULE_09 RULE_13
      acc_chan #(
        .STARTUP_CYC(STARTUP_CYC)
      ) u_chan (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .en_i(en_w[c]), // RULE_05
        .single_i(single_w[c]),
        .halt_i(halt_w[c]),
        .intsel_i(intsel_w[2*c +: 2]),
        .flen_i(flen_w[2*c +: 2]),
        .start_i(start_i[c]),
        .tick_i(sample_tick_i), // RULE_11
        .raw_i(comp_raw_i[c]),
        .state_o(st_w[c]),
        .ready_o(rdy_w[c]),
        .done_o(done_w[c]),
        .int_o(int_w[c])
      );
    end
  endgenerate

  // window: both high is above, both low is below, otherwise inside
  wire any_done = |done_w;
  wire inside_w = st_w[0] ^ st_w[1]; // RULE_04
  wire above_w = st_w[0] & st_w[1]; // RULE_04
  wire below_w = ~st_w[0] & ~st_w[1]; // RULE_04
  wire cond_w = (win_sel_w == ACC_WIN_ABOVE) ? above_w :
                (win_sel_w == ACC_WIN_INSIDE) ? inside_w :
                (win_sel_w == ACC_WIN_BELOW) ? below_w : ~inside_w; // RULE_02
  // channel results land with done, so the window is judged one cycle after them
  logic win_chk_ff;
  wire win_int = win_en_w && win_chk_ff && cond_w && !win_cond_ff; // RULE_02
  wire [2:0] set_w = {win_int, int_w}; // RULE_01
  wire [2:0] nxt_flags = (flags_o & ~flag_clr_i) | set_w; // RULE_19

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pend_ff <= ACC_CFG_RST;
      act_ff <= ACC_CFG_RST;
      sync_busy_o <= 1'b0;
      wp_err_o <= 1'b0;
    end else begin
      wp_err_o <= wr_bad; // RULE_14
      if (wr_ok) begin
        pend_ff <= cfg_w;
      end
      if (apply) begin
        act_ff <= pend_ff; // RULE_12
      end
      sync_busy_o <= wr_ok || (sync_busy_o && !apply); // RULE_12
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      raw_pin_ff <= 2'h0;
      cmp_pin_o <= 2'h0;
      comp_on_o <= 2'h0;
      mux_pos_o <= 4'h0;
      mux_neg_o <= 6'h0;
      scaler_o <= 12'h0;
    end else begin
      raw_pin_ff <= comp_raw_i;
      cmp_pin_o <= (outsync_w & st_w) | (~outsync_w & raw_pin_ff); // RULE_06
      comp_on_o <= en_w & ~halt_w;
      mux_pos_o <= act_ff[ACC_CF_POS +: 4]; // RULE_08
      mux_neg_o <= act_ff[ACC_CF_NEG +: 6]; // RULE_08
      scaler_o <= act_ff[ACC_CF_SCALER +: 12]; // RULE_08
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      win_chk_ff <= 1'b0;
      win_cond_ff <= 1'b0;
      win_inside_ff <= 1'b0;
      win_inside_o <= 1'b0;
      comp_state_o <= 2'h0;
      comp_ready_o <= 2'h0;
      evt_comp_o <= 2'h0;
      evt_win_o <= 1'b0;
      flags_o <= ACC_FLAG_RST;
      irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      win_chk_ff <= any_done;
      if (win_chk_ff) begin
        win_cond_ff <= cond_w;
        win_inside_ff <= inside_w;
      end
      win_inside_o <= win_inside_ff; // RULE_03
      comp_state_o <= st_w;
      comp_ready_o <= rdy_w;
      // events need no wake-up, so they flow in sleep as well
      evt_comp_o <= done_w; // RULE_03 RULE_10
      evt_win_o <= win_en_w && win_chk_ff && (inside_w != win_inside_ff); // RULE_03
      flags_o <= nxt_flags; // RULE_19
      irq_o <= |(nxt_flags & int_mask_i); // RULE_19
      wake_o <= sleep_i && |(nxt_flags & int_mask_i); // RULE_09
    end
  end
endmodule

// ===== acc_pkg.sv
// Operation
// RULE_01: each comparator interrupts on rising, falling, toggle or end of comparison
// RULE_02: window pair interrupts on signal above, inside, below or outside window
// RULE_03: events come from each comparator state and the window inside/outside result
// RULE_04: the two comparators combine into a window judged against their range
// RULE_05: two identical comparator channels, each with its own settings
// RULE_06: comparator state goes to a pin, unsampled or sampled, as configured
// RULE_07: optional digital filter on each sampled output before status and events
// RULE_08: input mux: four shared pins, ground, bandgap, 64-level scaler, DAC
// RULE_09: keeps running in sleep when allowed; interrupts can wake the system
// RULE_10: events issued during sleep reach others without leaving sleep
// RULE_11: the sampling clock rate sets when comparator outputs are sampled
// RULE_12: configuration writes are synchronized to sampling before taking effect
// RULE_13: runs on during debug halt unless configured to halt
// RULE_14: writes are write-protectable except start and interrupt flag clear; int_mask_i is not write-protected here either
// RULE_15: write protection never blocks writes from the external debugger
// RULE_16: result is one when positive input exceeds negative, else zero
// RULE_17: start clears ready, runs one comparison; ready sets when it completes
// RULE_18: edges found by comparing the current sample with the previous one
// RULE_19: flags stay set until cleared; irq high while an enabled flag is set
package acc_pkg;
  localparam int ACC_CLK_PERIOD_NS = 100;
  localparam int ACC_STARTUP_NS = 1000;
  localparam int ACC_STARTUP_CYC = (ACC_STARTUP_NS + ACC_CLK_PERIOD_NS - 1) / ACC_CLK_PERIOD_NS;
  localparam int ACC_NCH = 2;
  // interrupt source selection
  localparam logic [1:0] ACC_INT_TOGGLE = 2'h0;
  localparam logic [1:0] ACC_INT_RISE = 2'h1;
  localparam logic [1:0] ACC_INT_FALL = 2'h2;
  localparam logic [1:0] ACC_INT_EOC = 2'h3;
  // window interrupt selection
  localparam logic [1:0] ACC_WIN_ABOVE = 2'h0;
  localparam logic [1:0] ACC_WIN_INSIDE = 2'h1;
  localparam logic [1:0] ACC_WIN_BELOW = 2'h2;
  localparam logic [1:0] ACC_WIN_OUTSIDE = 2'h3;
  // filter length
  localparam logic [1:0] ACC_FLT_OFF = 2'h0;
  localparam logic [1:0] ACC_FLT_MAJ3 = 2'h1;
  localparam logic [1:0] ACC_FLT_MAJ5 = 2'h2;
  // negative input selection; codes 0..3 are the shared pins
  localparam logic [2:0] ACC_NEG_GND = 3'h4;
  localparam logic [2:0] ACC_NEG_BANDGAP = 3'h5;
  localparam logic [2:0] ACC_NEG_SCALER = 3'h6;
  localparam logic [2:0] ACC_NEG_DAC = 3'h7;
  // configuration vector layout
  localparam int ACC_CF_EN = 0;
  localparam int ACC_CF_SINGLE = 2;
  localparam int ACC_CF_INTSEL = 4;
  localparam int ACC_CF_FLEN = 8;
  localparam int ACC_CF_POS = 12;
  localparam int ACC_CF_NEG = 16;
  localparam int ACC_CF_SCALER = 22;
  localparam int ACC_CF_OUTSYNC = 34;
  localparam int ACC_CF_RUNSTBY = 36;
  localparam int ACC_CF_WINEN = 38;
  localparam int ACC_CF_WINSEL = 39;
  localparam int ACC_CF_DBGHALT = 41;
  localparam int ACC_CFG_W = 42;
  localparam logic [ACC_CFG_W-1:0] ACC_CFG_RST = 42'h0;
  localparam logic [2:0] ACC_FLAG_RST = 3'h0;
  typedef enum logic [1:0] {ACC_IDLE, ACC_STARTUP, ACC_RUN} acc_chan_st_t;
endpackage

// ===== acc_chan.sv
`timescale 1ns/1ps
module acc_chan
  import acc_pkg::*;
#(
  parameter int STARTUP_CYC = ACC_STARTUP_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // settings
  input wire logic en_i,
  input wire logic single_i,
  input wire logic halt_i,
  input wire logic [1:0] intsel_i,
  input wire logic [1:0] flen_i,
  // control and analog
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic raw_i,
  // results
  output logic state_o,
  output logic ready_o,
  output logic done_o,
  output logic int_o
);
  function automatic logic [2:0] acc_ones(input logic [4:0] v);
    acc_ones = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]);
  endfunction

  acc_chan_st_t st_ff;
  logic [15:0] cnt_ff;
  logic [4:0] hist_ff;
  logic raw_ff;
  wire [4:0] new_hist = {hist_ff[3:0], raw_ff};
  wire maj3 = acc_ones({2'h0, new_hist[2:0]}) >= 3'h2; // RULE_07
  wire maj5 = acc_ones(new_hist) >= 3'h3; // RULE_07
  wire filt = (flen_i == ACC_FLT_MAJ3) ? maj3 : (flen_i == ACC_FLT_MAJ5) ? maj5 : raw_ff; // RULE_07
  wire take = (st_ff == ACC_RUN) && en_i && tick_i && !halt_i; // RULE_11 RULE_13
  // previous sample is state_o itself, so single-shot edges span measurements
  wire rise = filt && !state_o; // RULE_18
  wire fall = !filt && state_o; // RULE_18
  wire hit = (intsel_i == ACC_INT_TOGGLE) ? (rise || fall) :
             (intsel_i == ACC_INT_RISE) ? rise :
             (intsel_i == ACC_INT_FALL) ? fall : 1'b1; // RULE_01
  wire up_done = (st_ff == ACC_STARTUP) && !halt_i && (cnt_ff == 16'(STARTUP_CYC - 1));

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_ff <= ACC_IDLE;
      cnt_ff <= 16'h0;
      hist_ff <= 5'h0;
      raw_ff <= 1'b0;
      state_o <= 1'b0;
      ready_o <= 1'b0;
      done_o <= 1'b0;
      int_o <= 1'b0;
    end else begin
      raw_ff <= raw_i; // RULE_16
      done_o <= take;
      int_o <= take && hit; // RULE_01
      if (take) begin
        hist_ff <= new_hist;
        state_o <= filt;
        ready_o <= 1'b1; // RULE_17
      end
      case (st_ff)
        ACC_IDLE: begin
          cnt_ff <= 16'h0;
          if (en_i && !single_i) begin
            st_ff <= ACC_STARTUP;
          end else if (en_i && start_i) begin
            st_ff <= ACC_STARTUP;
            ready_o <= 1'b0; // RULE_17
          end else if (!en_i) begin
            ready_o <= 1'b0;
          end
        end
        ACC_STARTUP: begin
          if (!en_i) begin
            st_ff <= ACC_IDLE;
          end else if (up_done) begin
            st_ff <= ACC_RUN;
          end else if (!halt_i) begin
            cnt_ff <= cnt_ff + 16'h1;
          end
        end
        ACC_RUN: begin
          if (!en_i || (take && single_i)) begin
            st_ff <= ACC_IDLE; // RULE_17
          end
        end
        default: begin
          st_ff <= ACC_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== acc_analog_model.sv
`timescale 1ns/1ps
module acc_analog_model #(
  parameter int BANDGAP_LVL = 40
) (
  // clock for the idle chatter
  input wire logic clk_sys_i,
  // active settings from the block
  input wire logic [1:0] comp_on_i,
  input wire logic [3:0] mux_pos_i,
  input wire logic [5:0] mux_neg_i,
  input wire logic [11:0] scaler_i,
  // levels, 8 bits per pin
  input wire logic [31:0] pin_lvl_i,
  input wire logic [7:0] dac_lvl_i,
  // comparator results
  output logic [1:0] comp_raw_o
);
  logic chat_ff = 1'b0;
  // a powered-down comparator has no valid result, so it chatters
  always @(posedge clk_sys_i) chat_ff <= ~chat_ff;
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [7:0] neg;
    logic [7:0] pos;
    always_comb begin
      case (mux_neg_i[3*c+:3])
        3'h4: neg = 8'h00;
        3'h5: neg = 8'(BANDGAP_LVL);
        3'h6: neg = {scaler_i[6*c+:6], 2'h0};
        3'h7: neg = dac_lvl_i;
        default: neg = pin_lvl_i[8*mux_neg_i[3*c+:2]+:8];
      endcase
    end
    assign pos = pin_lvl_i[8*mux_pos_i[2*c+:2]+:8];
    assign comp_raw_o[c] = comp_on_i[c] ? (pos > neg) : chat_ff;
  end
endmodule

// ===== acc_ctrl_asserts.sv
`timescale 1ns/1ps
module acc_ctrl_asserts (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // inputs watched
  input wire logic sample_tick_i,
  input wire logic cfg_we_i,
  input wire logic wp_en_i,
  input wire logic dbg_access_i,
  input wire logic [2:0] flag_clr_i,
  input wire logic [2:0] int_mask_i,
  input wire logic sleep_i,
  // outputs watched
  input wire logic sync_busy_o,
  input wire logic wp_err_o,
  input wire logic [1:0] comp_ready_o,
  input wire logic [2:0] flags_o,
  input wire logic [1:0] evt_comp_o,
  input wire logic irq_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_refused;
    cfg_we_i && wp_en_i && !dbg_access_i;
  endsequence
  sequence s_taken;
    cfg_we_i && !(wp_en_i && !dbg_access_i);
  endsequence
  a_refused_write: assert property (s_refused |=> wp_err_o)
    else $error("refused write not flagged");
  a_debug_write: assert property (s_taken |=> sync_busy_o && !wp_err_o)
    else $error("taken write not pending");
  a_busy_ends: assert property (sync_busy_o && sample_tick_i && !cfg_we_i |=> !sync_busy_o)
    else $error("busy outlived sample tick");
  a_flag_sticky: assert property (1 |=> ($past(flags_o) & ~$past(flag_clr_i) & ~flags_o) == 3'h0)
    else $error("flag lost without clear");
  a_irq_level: assert property (1 |=> irq_o == |(flags_o & $past(int_mask_i)))
    else $error("irq level wrong");
  a_wake_level: assert property (1 |=> wake_o == ($past(sleep_i) && irq_o))
    else $error("wake level wrong");
  a_event_after_tick: assert property (evt_comp_o != 2'h0 |-> $past(sample_tick_i, 2))
    else $error("event without sample");
  a_ready_on_done: assert property ((comp_ready_o & ~$past(comp_ready_o) & ~evt_comp_o) == 2'h0)
    else $error("ready rose without result");
endmodule
bind acc_ctrl acc_ctrl_asserts u_chk (.clk_sys_i, .rst_n_i, .sample_tick_i, .cfg_we_i, .wp_en_i,
  .dbg_access_i, .flag_clr_i, .int_mask_i, .sleep_i, .sync_busy_o, .wp_err_o, .comp_ready_o,
  .flags_o, .evt_comp_o, .irq_o, .wake_o);

// ===== acc_ctrl_bench.sv
`timescale 1ns/1ps
module acc_ctrl_bench;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, sample_tick_i = 1'b0, cfg_we_i = 1'b0;
  logic wp_en_i = 1'b0, dbg_access_i = 1'b0, win_en_i = 1'b0, dbg_halt_i = 1'b0;
  logic sleep_i = 1'b0, cpu_halted_i = 1'b0;
  logic [1:0] comp_en_i = 2'h0, single_i = 2'h0, out_sync_i = 2'h3, run_stby_i = 2'h3;
  logic [1:0] win_sel_i = 2'h1, start_i = 2'h0, tcnt = 2'h0;
  logic [3:0] intsel_i = 4'h0, flen_i = 4'h0, mux_pos_i = 4'h8;
  logic [5:0] mux_neg_i = 6'h00;
  logic [11:0] scaler_i = 12'h000;
  logic [2:0] flag_clr_i = 3'h0, int_mask_i = 3'h1;
  logic [1:0] comp_raw_i, comp_on_o, cmp_pin_o, comp_state_o, comp_ready_o, evt_comp_o;
  logic [3:0] mux_pos_o;
  logic [5:0] mux_neg_o;
  logic [11:0] scaler_o;
  logic [2:0] flags_o;
  logic win_inside_o, sync_busy_o, wp_err_o, evt_win_o, irq_o, wake_o;
  int mismatches = 0;
  int comparisons = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  // strobe every fourth clock stands in for the slower sampling clock
  always @(posedge clk_sys_i) begin
    tcnt <= tcnt + 2'h1;
    sample_tick_i <= #10 (tcnt == 2'h3);
  end
  acc_ctrl #(.STARTUP_CYC(2)) u_dut (.clk_sys_i, .rst_n_i, .sample_tick_i, .cfg_we_i, .wp_en_i,
    .dbg_access_i, .comp_en_i, .single_i, .intsel_i, .flen_i, .mux_pos_i, .mux_neg_i, .scaler_i,
    .out_sync_i, .run_stby_i, .win_en_i, .win_sel_i, .dbg_halt_i, .start_i, .flag_clr_i, .int_mask_i,
    .sleep_i, .cpu_halted_i, .comp_raw_i, .comp_on_o, .mux_pos_o, .mux_neg_o, .scaler_o, .cmp_pin_o,
    .comp_state_o, .comp_ready_o, .win_inside_o, .flags_o, .sync_busy_o, .wp_err_o, .evt_comp_o,
    .evt_win_o, .irq_o, .wake_o);
  acc_analog_model u_ana (.clk_sys_i, .comp_on_i(comp_on_o), .mux_pos_i(mux_pos_o),
    .mux_neg_i(mux_neg_o), .scaler_i(scaler_o), .pin_lvl_i(32'h10503090), .dac_lvl_i(8'h80),
    .comp_raw_o(comp_raw_i));
  task automatic go(input int n);
    repeat (n) @(posedge clk_sys_i);
    #10;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] en, sgl, input logic [3:0] isel, input logic [5:0] neg,
    input logic [11:0] scl, input logic ok);
    go(1);
    {comp_en_i, single_i, intsel_i, mux_neg_i, scaler_i} = {en, sgl, isel, neg, scl};
    cfg_we_i = 1'b1;
    go(1);
    cfg_we_i = 1'b0;
    chk("busy err", {10'h0, ok, !ok}, {10'h0, sync_busy_o, wp_err_o});
    for (int i = 0; i < 8 && sync_busy_o; i++) go(1);
    go(1);
    if (ok) chk("mux", {neg, 2'h0, 4'h8}, {mux_neg_o, 2'h0, mux_pos_o});
    if (ok) chk("scaler", scl, scaler_o);
  endtask
  task automatic wait_flag(input int b);
    for (int i = 0; i < 60 && flags_o[b] !== 1'b1; i++) go(1);
  endtask
  task automatic t_reset();
    chk("reset", 12'h0, {flags_o, irq_o, sync_busy_o, comp_ready_o, comp_state_o, evt_comp_o, wake_o});
    $display("reset test done");
  endtask
  task automatic t_cont();
    wp_en_i = 1'b1;
    wr(2'h1, 2'h0, 4'h1, 6'h06, 12'h014, 1'b0);
    dbg_access_i = 1'b1;
    wr(2'h1, 2'h0, 4'h1, 6'h06, 12'h014, 1'b1);
    {dbg_access_i, wp_en_i, sleep_i} = 3'h1;
    wait_flag(0);
    chk("rise", 12'hF, {comp_state_o[0], flags_o[0], irq_o, wake_o});
    chk("sync pin", 12'h1, {11'h0, cmp_pin_o[0]});
    go(5);
    chk("held", 12'h1, {11'h0, flags_o[0]});
    flag_clr_i = 3'h1;
    go(1);
    flag_clr_i = 3'h0;
    go(1);
    chk("clear", 12'h0, {flags_o[0], irq_o, wake_o});
    {sleep_i, out_sync_i, flen_i} = 7'h02;
    wr(2'h1, 2'h0, 4'h2, 6'h06, 12'h028, 1'b1);
    go(2);
    chk("raw pin", 12'h1, {10'h0, cmp_pin_o[0], comp_state_o[0]});
    go(7);
    chk("filter", 12'h1, {11'h0, comp_state_o[0]});
    wait_flag(0);
    chk("fall", 12'h1, {comp_state_o[0], flags_o[0]});
    $display("continuous test done");
  endtask
  task automatic t_single();
    win_en_i = 1'b1;
    wr(2'h3, 2'h2, 4'hE, 6'h2E, 12'h028, 1'b1);
    for (int k = 0; k < 2; k++) begin
      {start_i, flag_clr_i} = 5'h12;
      go(1);
      {start_i, flag_clr_i} = 5'h00;
      go(1);
      chk("ready low", 12'h0, {11'h0, comp_ready_o[1]});
      for (int i = 0; i < 40 && comp_ready_o[1] !== 1'b1; i++) go(1);
      chk("single", 12'h7, {comp_ready_o[1], comp_state_o[1], flags_o[1]});
      chk("comp event", 12'h1, {11'h0, evt_comp_o[1]});
      if (k == 0) begin
        go(1);
        chk("win event", 12'h3, {10'h0, evt_win_o, flags_o[2]});
      end
    end
    go(2);
    chk("window", 12'h3, {win_inside_o, flags_o[2]});
    chk("powered", 12'h3, {10'h0, comp_on_o});
    cpu_halted_i = 1'b1;
    go(2);
    chk("debug run", 12'h3, {10'h0, comp_on_o});
    dbg_halt_i = 1'b1;
    wr(2'h3, 2'h2, 4'hE, 6'h2E, 12'h028, 1'b1);
    chk("debug halt", 12'h0, {10'h0, comp_on_o});
    $display("single and window test done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    mismatches++;
    close_out();
  end
  initial begin
    go(6);
    rst_n_i = 1'b1;
    go(1);
    t_reset();
    t_cont();
    t_single();
    close_out();
  end
endmodule
